/* hdl/wasm_top.sv */
// wetting current auto-scaling and supply measurement control
module wasm_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // detection cycle and input configuration
    input wire logic cycle_end,
    input wire logic continuous_mode,
    input wire logic [23:0] adc_mode,
    input wire logic [23:0] in_above_comp,
    input wire logic [23:0] in_above_mapped,
    input wire logic [23:0] in_above_two_b,
    input wire logic [23:0] in_above_three_c,
    input wire logic [23:0] in_above_nine,
    input wire logic [71:0] wetting_setting,
    input wire logic [1:0] detection_filter_field,
    input wire logic source_group_scaling_off,
    input wire logic sink_group_scaling_off,
    input wire logic [23:0] current_source,
    // temperature
    input wire logic temperature_warning,
    input wire logic thermal_shutdown,
    // supply measurement
    input wire logic supply_measure_enable,
    input wire logic supply_range_select,
    input wire logic [9:0] supply_level_9v,
    input wire logic [9:0] supply_level_30v,
    input wire logic adc_done,
    input wire logic [9:0] supply_cmp0_low_threshold,
    input wire logic [9:0] supply_cmp0_high_threshold,
    input wire logic [9:0] supply_cmp1_low_threshold,
    input wire logic [9:0] supply_cmp1_high_threshold,
    input wire logic [1:0] supply_cmp0_edge_select,
    input wire logic [1:0] supply_cmp1_edge_select,
    input wire logic supply_cmp0_pin_enable,
    input wire logic supply_cmp1_pin_enable,
    input wire logic status_read,
    // outputs
    output logic [71:0] wetting_applied,
    output logic adc_start,
    output logic cycle_extend,
    output logic [9:0] supply_result_register,
    output logic [1:0] supply_cmp0_state,
    output logic [1:0] supply_cmp1_state,
    output logic supply_cmp0_flag,
    output logic supply_cmp1_flag,
    output logic temp_flag,
    output logic supply_threshold_spi_flag,
    output logic int_n
);
    // closure decision by mode and input number
    function automatic logic closed_of(input int i, input logic [23:0] adc_m,
        input logic [23:0] c, input logic [23:0] m, input logic [23:0] b,
        input logic [23:0] t, input logic [23:0] n);
        if (!adc_m[i]) return c[i];
        if (i < wasm_pkg::IN_2B_LO) return m[i];
        if (i < wasm_pkg::IN_3C_LO) return b[i];
        if (i < wasm_pkg::IN_NINE) return t[i];
        return n[i];
    endfunction : closed_of

    // cycles needed for a stable state
    function automatic logic [2:0] need_of(input logic [1:0] f);
        return 3'(f) + 3'h1;
    endfunction : need_of

    // one comparator state: bit0 above A, bit1 above B
    function automatic logic [1:0] cmp_of(input logic [9:0] v, input logic [9:0] a,
        input logic [9:0] b);
        return {v > b, v > a};
    endfunction : cmp_of

    // edge select hit between old and new state
    function automatic logic hit_of(input logic [1:0] o, input logic [1:0] n,
        input logic [1:0] sel);
        logic rise;
        logic fall;
        rise = |(n & ~o);
        fall = |(o & ~n);
        case (sel)
            wasm_pkg::EDGE_RISE: return rise;
            wasm_pkg::EDGE_FALL: return fall;
            wasm_pkg::EDGE_BOTH: return rise | fall;
            default: return 1'b0;
        endcase
    endfunction : hit_of

    // auto-scaling state
    logic [23:0] seen_reg, seen_next;
    logic [23:0] low_reg, low_next;
    logic [2:0] stab_reg [24];
    logic [2:0] stab_next [24];
    logic [71:0] wet_reg, wet_next;

    always_comb begin
        seen_next = seen_reg;
        low_next = low_reg;
        wet_next = wet_reg;
        for (int i = 0; i < wasm_pkg::NUM_IN; i++) begin
            logic c;
            logic hi;
            logic off;
            logic [2:0] s;
            c = closed_of(i, adc_mode, in_above_comp, in_above_mapped,
                in_above_two_b, in_above_three_c, in_above_nine);
            hi = (wetting_setting[i*3 +: 3] == wasm_pkg::CUR_10MA) ||
                (wetting_setting[i*3 +: 3] == wasm_pkg::CUR_15MA);
            off = current_source[i] ? source_group_scaling_off : sink_group_scaling_off;
            s = stab_reg[i];
            stab_next[i] = s;
            if (cycle_end) begin
                seen_next[i] = c;
                // counter restarts on every change of detected state
                if (c != seen_reg[i]) begin
                    stab_next[i] = 3'h1;
                end else if (s < wasm_pkg::STAB_MAX) begin
                    stab_next[i] = s + 3'h1;
                end
                if (((c != seen_reg[i]) ? 3'h1 : s + 3'h1) >= need_of(detection_filter_field)
                    || (c == seen_reg[i] && s >= need_of(detection_filter_field))) begin
                    low_next[i] = c;
                end
            end
            // scaling only for high settings in continuous mode with group enabled
            if (low_reg[i] && hi && continuous_mode && !off) begin
                wet_next[i*3 +: 3] = wasm_pkg::CUR_2MA;
            end else begin
                wet_next[i*3 +: 3] = wetting_setting[i*3 +: 3];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seen_reg <= '0;
            low_reg <= '0;
            wet_reg <= '0;
            for (int i = 0; i < wasm_pkg::NUM_IN; i++) stab_reg[i] <= '0;
        end else begin
            seen_reg <= seen_next;
            low_reg <= low_next;
            wet_reg <= wet_next;
            for (int i = 0; i < wasm_pkg::NUM_IN; i++) stab_reg[i] <= stab_next[i];
        end
    end
    assign wetting_applied = wet_reg;

    // supply measurement state
    wasm_pkg::wasm_state_t st_reg, st_next;
    logic base_reg, base_next;
    logic [9:0] res_reg, res_next;
    logic [1:0] s0_reg, s0_next, s1_reg, s1_next;
    logic f0_reg, f0_next, f1_reg, f1_next, ft_reg, ft_next;
    logic tw_d_reg, tsd_d_reg;
    logic p0_reg, p0_next, p1_reg, p1_next;
    logic go_reg, go_next, ext_reg, ext_next, intn_reg, intn_next;
    logic spi_reg, spi_next;

    always_comb begin
        logic [9:0] code;
        logic [1:0] n0;
        logic [1:0] n1;
        logic h0;
        logic h1;
        code = supply_range_select ? supply_level_30v : supply_level_9v;
        n0 = cmp_of(code, supply_cmp0_low_threshold, supply_cmp0_high_threshold);
        n1 = cmp_of(code, supply_cmp1_low_threshold, supply_cmp1_high_threshold);
        st_next = st_reg;
        base_next = base_reg;
        res_next = res_reg;
        s0_next = s0_reg;
        s1_next = s1_reg;
        f0_next = f0_reg;
        f1_next = f1_reg;
        p0_next = p0_reg;
        p1_next = p1_reg;
        go_next = 1'b0;
        ext_next = ext_reg;
        h0 = 1'b0;
        h1 = 1'b0;
        // reading status clears flags; a same-cycle event below still sets them
        ft_next = status_read ? 1'b0 : ft_reg;
        if (status_read) begin
            f0_next = 1'b0;
            f1_next = 1'b0;
            p0_next = 1'b0;
            p1_next = 1'b0;
        end
        if ((temperature_warning && !tw_d_reg) || (thermal_shutdown && !tsd_d_reg)) begin
            ft_next = 1'b1;
        end
        if (!supply_measure_enable) base_next = 1'b0;
        case (st_reg)
            wasm_pkg::WASM_IDLE: begin
                if (cycle_end && supply_measure_enable) begin
                    st_next = wasm_pkg::WASM_CONV;
                    go_next = 1'b1;
                    ext_next = 1'b1;
                end
            end
            wasm_pkg::WASM_CONV: begin
                if (adc_done) begin
                    st_next = wasm_pkg::WASM_DONE;
                    ext_next = 1'b0;
                    res_next = (code > wasm_pkg::CODE_SAT) ? wasm_pkg::CODE_SAT : code;
                    s0_next = n0;
                    s1_next = n1;
                    h0 = !base_reg || hit_of(s0_reg, n0, supply_cmp0_edge_select);
                    h1 = !base_reg || hit_of(s1_reg, n1, supply_cmp1_edge_select);
                    base_next = 1'b1;
                end
            end
            wasm_pkg::WASM_DONE: st_next = wasm_pkg::WASM_IDLE;
            default: st_next = wasm_pkg::WASM_IDLE;
        endcase
        if (h0) begin
            f0_next = 1'b1;
            p0_next = supply_cmp0_pin_enable || !base_reg;
        end
        if (h1) begin
            f1_next = 1'b1;
            p1_next = supply_cmp1_pin_enable || !base_reg;
        end
        intn_next = !(p0_next || p1_next || ft_next);
        // registered so the spi flag leaves the block from a flip-flop
        spi_next = f0_next || f1_next;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= wasm_pkg::WASM_IDLE;
            base_reg <= 1'b0;
            res_reg <= '0;
            s0_reg <= '0;
            s1_reg <= '0;
            f0_reg <= 1'b0;
            f1_reg <= 1'b0;
            ft_reg <= 1'b0;
            tw_d_reg <= 1'b0;
            tsd_d_reg <= 1'b0;
            p0_reg <= 1'b0;
            p1_reg <= 1'b0;
            go_reg <= 1'b0;
            ext_reg <= 1'b0;
            intn_reg <= 1'b1;
            spi_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            base_reg <= base_next;
            res_reg <= res_next;
            s0_reg <= s0_next;
            s1_reg <= s1_next;
            f0_reg <= f0_next;
            f1_reg <= f1_next;
            ft_reg <= ft_next;
            tw_d_reg <= temperature_warning;
            tsd_d_reg <= thermal_shutdown;
            p0_reg <= p0_next;
            p1_reg <= p1_next;
            go_reg <= go_next;
            ext_reg <= ext_next;
            intn_reg <= intn_next;
            spi_reg <= spi_next;
        end
    end

    assign adc_start = go_reg;
    assign cycle_extend = ext_reg;
    assign supply_result_register = res_reg;
    assign supply_cmp0_state = s0_reg;
    assign supply_cmp1_state = s1_reg;
    assign supply_cmp0_flag = f0_reg;
    assign supply_cmp1_flag = f1_reg;
    assign temp_flag = ft_reg;
    assign supply_threshold_spi_flag = spi_reg;
    assign int_n = intn_reg;

    a_first_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_reg == wasm_pkg::WASM_CONV && adc_done && !base_reg |=> f0_reg && f1_reg && !int_n)
        else $error("first supply result did not interrupt");
    a_read_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        status_read && !adc_done && !temperature_warning && !thermal_shutdown |=> !f0_reg)
        else $error("status read did not clear flag");
    a_edge_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        base_reg && supply_cmp0_edge_select == wasm_pkg::EDGE_OFF && !f0_reg |=> !f0_reg)
        else $error("disabled comparator set its flag");
    a_no_meas: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_reg == wasm_pkg::WASM_IDLE && !(cycle_end && supply_measure_enable) |=> !adc_start)
        else $error("conversion started without enable");
    a_sat_code: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_reg == wasm_pkg::WASM_CONV && adc_done && !supply_range_select
        && supply_level_9v == wasm_pkg::CODE_SAT |=> supply_result_register == wasm_pkg::CODE_SAT)
        else $error("saturated supply code not stored");
    a_spi_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        supply_threshold_spi_flag == (supply_cmp0_flag || supply_cmp1_flag))
        else $error("spi flag missing");
    a_temp_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(temperature_warning) |=> ##1 !int_n)
        else $error("temperature warning did not interrupt");
    a_poll_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
        !continuous_mode |=> wetting_applied == $past(wetting_setting))
        else $error("scaling applied in polling mode");
endmodule : wasm_top

/* hdl/wasm_pkg.sv */
// constants and types for the wetting auto-scale and supply measurement block
// What this block does
// - closed switch drops high wetting current to 2mA
// - comparator-mode inputs use comparator threshold setting
// - ADC inputs use threshold by input number
// - filter 00 reduces in next detection cycle
// - filter 01/10/11 need 2/3/4 stable cycles
// - restore after same filtered count on open
// - only 10/15mA settings, continuous mode only
// - group disable bit keeps original current
// - interrupt on temperature warning or shutdown
// - supply measured at end of each cycle
// - one extra conversion time, result stored
// - range bit 0: above 9V saturates 1023
// - range bit 1: above 30V saturates 1023
// - two comparators with A/B threshold pairs
// - first cycle after enable always interrupts
// - report per-threshold state and spi flag
// - first result is baseline, then crossings only
// - rising, falling or both edge selection
// - edge select 0 sets no flag, no pin
// - pin enable 0 flags but masks pin
// - supply measurement disabled after reset
// - status read clears flags, releases pin
package wasm_pkg;
    localparam int NUM_IN = 24;
    localparam int NUM_SRC_GRP = 10;
    localparam logic [2:0] CUR_2MA = 3'h2;
    localparam logic [2:0] CUR_10MA = 3'h4;
    localparam logic [2:0] CUR_15MA = 3'h5;
    localparam logic [9:0] CODE_SAT = 10'h3ff;
    localparam int IN_2B_LO = 12;
    localparam int IN_3C_LO = 18;
    localparam int IN_NINE = 23;
    localparam logic [2:0] STAB_MAX = 3'h4;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    typedef enum logic [1:0] {WASM_IDLE, WASM_CONV, WASM_DONE} wasm_state_t;
endpackage : wasm_pkg

/* test/wasm_host.sv */
// host model: asks for an interrupt status read a chosen number of cycles after a request
module wasm_host (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // request from the bench, delay sets prompt or slow answers
    input wire logic rd_req,
    input wire logic [3:0] rd_delay,
    // towards the block
    output logic status_read
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h0;
            status_read <= 1'b0;
        end else begin
            // single-cycle read pulse, one read per request
            status_read <= (cnt == 5'h1);
            cnt <= rd_req ? {1'b0, rd_delay} + 5'h1 : (cnt != 5'h0 ? cnt - 5'h1 : 5'h0);
        end
    end
endmodule : wasm_host

/* test/tb_top.sv */
// self-checking bench for wetting auto-scale and supply measurement
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, resetn = 1'b0, cycle_end = 1'b0, continuous_mode = 1'b1;
    logic source_group_scaling_off = 1'b0, sink_group_scaling_off = 1'b0;
    logic temperature_warning = 1'b0, thermal_shutdown = 1'b0, adc_done = 1'b0;
    logic supply_measure_enable = 1'b0, supply_range_select = 1'b0, rd_req = 1'b0;
    logic supply_cmp0_pin_enable = 1'b1, supply_cmp1_pin_enable = 1'b0;
    logic [23:0] adc_mode = '0, in_above_comp = '0, in_above_mapped = '0, current_source = '0;
    logic [23:0] in_above_two_b = '0, in_above_three_c = '0, in_above_nine = '0;
    logic [71:0] wetting_setting = '0, wetting_applied;
    logic [1:0] detection_filter_field = '0, supply_cmp0_edge_select = 2'h3;
    logic [1:0] supply_cmp1_edge_select = 2'h3, supply_cmp0_state, supply_cmp1_state, p0, p1;
    logic [9:0] supply_level_9v = '0, supply_level_30v = '0, supply_result_register;
    // host keeps each high threshold at or above its low one
    logic [9:0] supply_cmp0_low_threshold = 10'h64, supply_cmp0_high_threshold = 10'hc8;
    logic [9:0] supply_cmp1_low_threshold = 10'hf0, supply_cmp1_high_threshold = 10'h104;
    logic adc_start, cycle_extend, supply_cmp0_flag, supply_cmp1_flag, temp_flag, int_n;
    logic supply_threshold_spi_flag, status_read, first, ce_d = 1'b0;
    logic [3:0] rd_delay = '0;
    logic [31:0] seed = 32'h5aea;
    logic [17:0] exp_q[$];
    int n_fail = 0, n_checks = 0, cyc = 0;
    wasm_top i_wasm_top (.sys_clk, .resetn, .cycle_end, .continuous_mode, .adc_mode,
        .in_above_comp, .in_above_mapped, .in_above_two_b, .in_above_three_c, .in_above_nine,
        .wetting_setting, .detection_filter_field, .source_group_scaling_off,
        .sink_group_scaling_off, .current_source, .temperature_warning, .thermal_shutdown,
        .supply_measure_enable, .supply_range_select, .supply_level_9v, .supply_level_30v,
        .adc_done, .supply_cmp0_low_threshold, .supply_cmp0_high_threshold,
        .supply_cmp1_low_threshold, .supply_cmp1_high_threshold, .supply_cmp0_edge_select,
        .supply_cmp1_edge_select, .supply_cmp0_pin_enable, .supply_cmp1_pin_enable,
        .status_read, .wetting_applied, .adc_start, .cycle_extend, .supply_result_register,
        .supply_cmp0_state, .supply_cmp1_state, .supply_cmp0_flag, .supply_cmp1_flag,
        .temp_flag, .supply_threshold_spi_flag, .int_n);
    wasm_host i_wasm_host (.sys_clk, .resetn, .rd_req, .rd_delay, .status_read);
    always #2.5 sys_clk = ~sys_clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic edg(input logic [1:0] e, input logic [1:0] p, input logic [1:0] s);
        return (e[0] & |(s & ~p)) | (e[1] & |(p & ~s));
    endfunction : edg
    task automatic chk(input logic [71:0] g, input logic [71:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic hread();
        rd_delay <= 4'(rnd());
        rd_req <= 1'b1;
        @(posedge sys_clk) rd_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
    endtask : hread
    // one supply conversion; the expectation is queued for the monitor
    task automatic conv(input logic [9:0] lvl, input logic rng);
        logic [1:0] s0, s1;
        logic f0, f1;
        @(posedge sys_clk);
        s0 = {lvl > supply_cmp0_high_threshold, lvl > supply_cmp0_low_threshold};
        s1 = {lvl > supply_cmp1_high_threshold, lvl > supply_cmp1_low_threshold};
        f0 = first | edg(supply_cmp0_edge_select, p0, s0);
        f1 = first | edg(supply_cmp1_edge_select, p1, s1);
        exp_q.push_back({lvl, s0, s1, f0, f1, f0 | f1,
            !(first | (f0 & supply_cmp0_pin_enable) | (f1 & supply_cmp1_pin_enable))});
        p0 = s0;
        p1 = s1;
        first = 1'b0;
        supply_range_select <= rng;
        supply_level_9v <= rng ? 10'(rnd()) : lvl;
        supply_level_30v <= rng ? lvl : 10'(rnd());
        cycle_end <= 1'b1;
        @(posedge sys_clk) cycle_end <= 1'b0;
        #1;
        chk(adc_start, 1'b1);
        repeat ((rnd() & 3) + 1) @(posedge sys_clk);
        chk(cycle_extend, 1'b1);
        adc_done <= 1'b1;
        @(posedge sys_clk) adc_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        hread();
        chk({supply_cmp0_flag, supply_cmp1_flag, int_n}, 3'h1);
    endtask : conv
    // closes then opens one input, checking the applied current after every cycle end
    task automatic scale(input int i, input logic ad, input logic [2:0] orig, input logic lo_ok);
        logic [23:0] v;
        logic [2:0] e;
        int need;
        // let a filter setting made just before the call settle first
        @(posedge sys_clk);
        need = detection_filter_field + 1;
        adc_mode[i] <= ad;
        wetting_setting[i*3 +: 3] <= orig;
        for (int ph = 0; ph < 2; ph++) begin
            v = (ph == 0) ? 24'h1 << i : 24'h0;
            for (int k = 1; k <= need; k++) begin
                @(posedge sys_clk);
                in_above_comp <= ad ? 24'h0 : v;
                in_above_mapped <= (ad && i < 12) ? v : 24'h0;
                in_above_two_b <= (ad && i >= 12 && i < 18) ? v : 24'h0;
                in_above_three_c <= (ad && i >= 18 && i < 23) ? v : 24'h0;
                in_above_nine <= (ad && i == 23) ? v : 24'h0;
                cycle_end <= 1'b1;
                @(posedge sys_clk) cycle_end <= 1'b0;
                repeat (2) @(posedge sys_clk);
                #1;
                e = (lo_ok && (ph == 0 ? k == need : k < need)) ? wasm_pkg::CUR_2MA : orig;
                chk(wetting_applied[i*3 +: 3], e);
            end
        end
    endtask : scale
    // monitor: a falling conversion-busy marks fresh results
    always @(negedge sys_clk) begin
        ce_d <= cycle_extend;
        if (ce_d === 1'b1 && cycle_extend === 1'b0) begin
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else chk({supply_result_register, supply_cmp0_state, supply_cmp1_state,
                supply_cmp0_flag, supply_cmp1_flag, supply_threshold_spi_flag, int_n},
                exp_q.pop_front());
        end
    end
    // hang guard, far above the roughly 800 cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk({int_n, supply_cmp0_flag, temp_flag, adc_start, cycle_extend}, 5'h10);
        @(posedge sys_clk) resetn <= 1'b1;
        @(posedge sys_clk) cycle_end <= 1'b1;
        @(posedge sys_clk) cycle_end <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({adc_start, cycle_extend}, 2'h0);
        for (int f = 0; f < 4; f++) begin
            detection_filter_field <= 2'(f);
            scale(0, 1'b0, wasm_pkg::CUR_15MA, 1'b1);
        end
        scale(5, 1'b1, wasm_pkg::CUR_10MA, 1'b1);
        scale(14, 1'b1, wasm_pkg::CUR_10MA, 1'b1);
        scale(20, 1'b1, wasm_pkg::CUR_15MA, 1'b1);
        scale(23, 1'b1, wasm_pkg::CUR_10MA, 1'b1);
        current_source[0] <= 1'b1;
        source_group_scaling_off <= 1'b1;
        scale(0, 1'b0, wasm_pkg::CUR_15MA, 1'b0);
        scale(2, 1'b0, wasm_pkg::CUR_15MA, 1'b1);
        source_group_scaling_off <= 1'b0;
        sink_group_scaling_off <= 1'b1;
        scale(0, 1'b0, wasm_pkg::CUR_15MA, 1'b1);
        scale(2, 1'b0, wasm_pkg::CUR_15MA, 1'b0);
        scale(3, 1'b0, 3'h3, 1'b0);
        continuous_mode <= 1'b0;
        scale(0, 1'b0, wasm_pkg::CUR_15MA, 1'b0);
        for (int j = 0; j < 2; j++) begin
            @(posedge sys_clk) {thermal_shutdown, temperature_warning} <= 2'h1 << j;
            repeat (3) @(posedge sys_clk);
            chk({temp_flag, int_n}, 2'h2);
            hread();
            chk({temp_flag, int_n}, 2'h1);
        end
        first = 1'b1;
        supply_measure_enable <= 1'b1;
        conv(10'h96, 1'b0);
        for (int e = 0; e < 4; e++) begin
            supply_cmp0_edge_select <= 2'(e);
            supply_cmp1_edge_select <= 2'(3 - e);
            conv(10'hfa, 1'b0);
            conv(10'h32, 1'b0);
        end
        supply_cmp0_pin_enable <= 1'b0;
        supply_cmp1_pin_enable <= 1'b1;
        conv(10'h96, 1'b1);
        conv(wasm_pkg::CODE_SAT, 1'b0);
        chk(exp_q.size(), 0);
        results();
    end
endmodule : tb_top
